// File: core/cafe_pkg.sv
package cafe_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_REGS = 16;

   localparam logic [3:0] ADDR_GAIN_0      = 4'h0;
   localparam logic [3:0] ADDR_GAIN_1      = 4'h1;
   localparam logic [3:0] ADDR_GAIN_2      = 4'h2;
   localparam logic [3:0] ADDR_GAIN_3      = 4'h3;
   localparam logic [3:0] ADDR_OFFSET_0    = 4'h4;
   localparam logic [3:0] ADDR_OFFSET_1    = 4'h5;
   localparam logic [3:0] ADDR_OFFSET_2    = 4'h6;
   localparam logic [3:0] ADDR_OFFSET_3    = 4'h7;
   localparam logic [3:0] ADDR_PAT_LINE0   = 4'h8;
   localparam logic [3:0] ADDR_PAT_LINE1   = 4'h9;
   localparam logic [3:0] ADDR_PAT_LENGTH  = 4'ha;
   localparam logic [3:0] ADDR_BLACK_LEVEL = 4'hb;
   localparam logic [3:0] ADDR_PRI_CTRL    = 4'hc;
   localparam logic [3:0] ADDR_SEC_CTRL    = 4'hd;
   localparam logic [3:0] ADDR_BIAS_A      = 4'he;
   localparam logic [3:0] ADDR_BIAS_B      = 4'hf;

   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [7:0] RST_BLACK_LEVEL = 8'h10;
   localparam logic [7:0] RST_PRI_CTRL    = 8'h4e;
   localparam logic [7:0] RST_SEC_CTRL    = 8'h00;
   localparam logic [7:0] RST_BIAS_A      = 8'haa;
   localparam logic [7:0] RST_BIAS_B      = 8'h5a;

   localparam int unsigned CTRL_AUTOCAL_BIT = 3;
   localparam int unsigned LEN_LINE0_LSB    = 0;
   localparam int unsigned LEN_LINE1_LSB    = 2;
   localparam logic [3:0]  LEN_USED_MASK    = 4'hf;

   // gain code step, in millidecibel
   localparam int unsigned GAIN_STEP_MDB = 125;

   typedef struct packed {
      logic       wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } cafe_req_t;

   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] offset;
      logic [1:0] slot;
   } cafe_pix_t;
endpackage : cafe_pkg

// File: core/cafe_reg_bank.sv
`timescale 1ns/1ps
module cafe_reg_bank (
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   input  wire cafe_pkg::cafe_req_t req_i,
   input  wire logic              req_valid_i,
   output logic [7:0]             rdata_o,
   output logic                   rdata_valid_o,
   input  wire logic              line_start_strobe_i,
   input  wire logic              pixel_tick_i,
   output cafe_pkg::cafe_pix_t    pix_o,
   output logic                   active_line_o,
   output logic [7:0]             black_level_o,
   output logic [7:0]             primary_control_o,
   output logic [7:0]             secondary_control_o,
   output logic [7:0]             bias_trim_a_o,
   output logic [7:0]             bias_trim_b_o
);
   import cafe_pkg::*;

   logic [7:0] regs_ff [NUM_REGS];
   logic       bol_meta_ff;
   logic       bol_sync_ff;
   logic       bol_prev_ff;
   logic       tick_meta_ff;
   logic       tick_sync_ff;
   logic       tick_prev_ff;
   logic       line_sel_ff;
   logic       seen_line_ff;
   logic [1:0] pos_ff;
   logic [7:0] rdata_ff;
   logic       rvalid_ff;
   cafe_pix_t  pix_ff;

   wire        autocal_on = regs_ff[ADDR_PRI_CTRL][CTRL_AUTOCAL_BIT];
   wire        is_offset  = (req_i.addr[3:2] == ADDR_OFFSET_0[3:2]);
   // offsets belong to the calibration loop while it runs
   wire        wr_block   = autocal_on && is_offset;
   wire        wr_en      = req_valid_i && req_i.wr && !wr_block;
   wire        bol_rise   = bol_sync_ff && !bol_prev_ff;
   wire        tick_rise  = tick_sync_ff && !tick_prev_ff;
   wire [7:0]  len_reg    = regs_ff[ADDR_PAT_LENGTH];
   // length field n means n+1 elements: 01 two, 11 four
   wire [1:0]  last_pos   = line_sel_ff ? len_reg[LEN_LINE1_LSB +: 2]
                                        : len_reg[LEN_LINE0_LSB +: 2];
   wire [7:0]  pat_word   = line_sel_ff ? regs_ff[ADDR_PAT_LINE1]
                                        : regs_ff[ADDR_PAT_LINE0];
   wire [1:0]  slot_sel   = pat_word[{pos_ff, 1'b0} +: 2];
   wire [1:0]  nxt_pos    = (pos_ff == last_pos) ? 2'h0 : pos_ff + 2'h1;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               regs_ff[g] <= (g == ADDR_BLACK_LEVEL) ? RST_BLACK_LEVEL :
                             (g == ADDR_PRI_CTRL)    ? RST_PRI_CTRL :
                             (g == ADDR_BIAS_A)      ? RST_BIAS_A :
                             (g == ADDR_BIAS_B)      ? RST_BIAS_B : RST_ZERO;
            end else if (wr_en && (req_i.addr == 4'(g))) begin
               regs_ff[g] <= req_i.wdata;
            end
         end
      end
   endgenerate

   // read path, one cycle after the request
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= req_valid_i && !req_i.wr;
         if (req_valid_i && !req_i.wr) begin
            rdata_ff <= (req_i.addr == ADDR_PAT_LENGTH) ? (len_reg & {4'h0, LEN_USED_MASK})
                                                        : regs_ff[req_i.addr];
         end
      end
   end

   // strobe and pixel tick come from the pins: two flops first
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bol_meta_ff  <= 1'b0;
         bol_sync_ff  <= 1'b0;
         bol_prev_ff  <= 1'b0;
         tick_meta_ff <= 1'b0;
         tick_sync_ff <= 1'b0;
         tick_prev_ff <= 1'b0;
      end else begin
         bol_meta_ff  <= line_start_strobe_i;
         bol_sync_ff  <= bol_meta_ff;
         bol_prev_ff  <= bol_sync_ff;
         tick_meta_ff <= pixel_tick_i;
         tick_sync_ff <= tick_meta_ff;
         tick_prev_ff <= tick_sync_ff;
      end
   end

   // first strobe after reset uses line 0, later strobes alternate
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_sel_ff  <= 1'b0;
         seen_line_ff <= 1'b0;
         pos_ff       <= 2'h0;
      end else begin
         if (bol_rise) begin
            seen_line_ff <= 1'b1;
            line_sel_ff  <= seen_line_ff ? !line_sel_ff : 1'b0;
            pos_ff       <= 2'h0;
         end else if (tick_rise && bol_sync_ff) begin
            pos_ff <= nxt_pos;
         end
      end
   end

   // registered pixel selection, stale by one cycle at most
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pix_ff <= '0;
      end else begin
         pix_ff.slot   <= slot_sel;
         pix_ff.gain   <= regs_ff[{2'b00, slot_sel}];
         pix_ff.offset <= regs_ff[{2'b01, slot_sel}];
      end
   end

   assign rdata_o             = rdata_ff;
   assign rdata_valid_o       = rvalid_ff;
   assign pix_o               = pix_ff;
   assign active_line_o       = line_sel_ff;
   // clamp loop and its 20-cycle request live outside this bank
   assign black_level_o       = regs_ff[ADDR_BLACK_LEVEL];
   assign primary_control_o   = regs_ff[ADDR_PRI_CTRL];
   assign secondary_control_o = regs_ff[ADDR_SEC_CTRL];
   assign bias_trim_a_o       = regs_ff[ADDR_BIAS_A];
   assign bias_trim_b_o       = regs_ff[ADDR_BIAS_B];
endmodule : cafe_reg_bank

// File: dv/cafe_reg_bank_chk.sv
`timescale 1ns/1ps
module cafe_reg_bank_chk (
   input wire logic                mclk_i,
   input wire logic                reset_n_i,
   input wire cafe_pkg::cafe_req_t req_i,
   input wire logic                req_valid_i,
   input wire logic [7:0]          rdata_o,
   input wire logic                rdata_valid_o,
   input wire logic [7:0]          black_level_o,
   input wire logic [7:0]          primary_control_o,
   input wire logic [7:0]          bias_trim_b_o
);
   import cafe_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire rd = req_valid_i && !req_i.wr;
   wire wr = req_valid_i && req_i.wr;
   a_rd_answer: assert property (rd |=> rdata_valid_o)
      else $error("read not answered");
   a_no_stray: assert property (!rd |=> !rdata_valid_o)
      else $error("stray read valid");
   a_black_load: assert property (wr && req_i.addr == ADDR_BLACK_LEVEL |=> black_level_o == $past(req_i.wdata))
      else $error("black level not loaded");
   a_black_keep: assert property (!(wr && req_i.addr == ADDR_BLACK_LEVEL) |=> $stable(black_level_o))
      else $error("black level changed");
   a_rd_black: assert property (rd && req_i.addr == ADDR_BLACK_LEVEL |=> rdata_o == $past(black_level_o))
      else $error("black level read wrong");
   a_len_upper: assert property (rd && req_i.addr == ADDR_PAT_LENGTH |=> rdata_o[7:4] == 4'h0)
      else $error("length upper bits set");
   a_ctrl_load: assert property (wr && req_i.addr == ADDR_PRI_CTRL |=> primary_control_o == $past(req_i.wdata))
      else $error("control not loaded");
   a_trim_keep: assert property (!(wr && req_i.addr == ADDR_BIAS_B) |=> $stable(bias_trim_b_o))
      else $error("trim changed");
   c_read: cover property (rd);
   c_black: cover property (wr && req_i.addr == ADDR_BLACK_LEVEL);
   c_ctrl: cover property (wr && req_i.addr == ADDR_PRI_CTRL);
endmodule : cafe_reg_bank_chk
bind cafe_reg_bank cafe_reg_bank_chk chk_u (.mclk_i, .reset_n_i, .req_i, .req_valid_i, .rdata_o, .rdata_valid_o,
   .black_level_o, .primary_control_o, .bias_trim_b_o);

// File: dv/cafe_host.sv
`timescale 1ns/1ps
module cafe_host (
   input  wire logic           mclk_i,
   input  wire logic [7:0]     rdata_i,
   input  wire logic           rdata_valid_i,
   output cafe_pkg::cafe_req_t req_o,
   output logic                req_valid_o,
   output logic                strobe_o,
   output logic                tick_o
);
   import cafe_pkg::*;
   // clamp request is outside this block, not driven here
   initial {req_o, req_valid_o, strobe_o, tick_o} = '0;
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk_i);
      req_o <= '{w, a, d};
      req_valid_o <= 1'b1;
      @(posedge mclk_i);
      req_valid_o <= 1'b0;
      #1 q = rdata_valid_i ? rdata_i : 8'hxx;
   endtask : xfer
   // low long enough for the synchroniser to see the new line
   task automatic line();
      @(posedge mclk_i) strobe_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      strobe_o <= 1'b1;
      repeat (6) @(posedge mclk_i);
   endtask : line
   task automatic tick();
      @(posedge mclk_i) tick_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      tick_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask : tick
endmodule : cafe_host

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import cafe_pkg::*;
   logic      mclk_i = 1'b0;
   logic      reset_n_i = 1'b0;
   cafe_req_t req;
   cafe_pix_t pix;
   logic      req_valid, strobe, tick, rvalid, act;
   logic [7:0] rdata, q, blk, pc, sc, ta, tb;
   int        n_errors = 0;
   int        tests_run = 0;
   localparam logic [7:0] DEF [16] = '{default: 8'h00, 11: 8'h10, 12: 8'h4e, 14: 8'haa, 15: 8'h5a};
   localparam logic [7:0] GN [4] = '{8'hff, 8'h00, 8'h00, 8'h01};
   localparam logic [7:0] OF [4] = '{8'h81, 8'h00, 8'h00, 8'h7f};
   localparam logic [7:0] ROWS [11][3] = '{'{8'h04, 8'h55, 8'h00}, '{8'h0c, 8'h46, 8'h46}, '{8'h04, 8'h81, 8'h81},
      '{8'h07, 8'h7f, 8'h7f}, '{8'h00, 8'hff, 8'hff}, '{8'h03, 8'h01, 8'h01}, '{8'h08, 8'he4, 8'he4},
      '{8'h09, 8'h1b, 8'h1b}, '{8'h0a, 8'hf7, 8'h07}, '{8'h0b, 8'h20, 8'h20}, '{8'h0d, 8'h3c, 8'h3c}};
   always #50 mclk_i = ~mclk_i;
   cafe_reg_bank dut_u (.mclk_i, .reset_n_i, .req_i(req), .req_valid_i(req_valid), .rdata_o(rdata),
      .rdata_valid_o(rvalid), .line_start_strobe_i(strobe), .pixel_tick_i(tick), .pix_o(pix), .active_line_o(act),
      .black_level_o(blk), .primary_control_o(pc), .secondary_control_o(sc), .bias_trim_a_o(ta),
      .bias_trim_b_o(tb));
   cafe_host host_u (.mclk_i, .rdata_i(rdata), .rdata_valid_i(rvalid), .req_o(req), .req_valid_o(req_valid),
      .strobe_o(strobe), .tick_o(tick));
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", s, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic pat(input logic [7:0] w, input int len, input int n);
      logic [7:0] e;
      for (int i = 0; i < n; i++) begin
         e = (w >> (2 * (i % len))) & 8'h03;
         chk("slot", e, {6'h00, pix.slot});
         chk("gain", GN[e[1:0]], pix.gain);
         chk("offset", OF[e[1:0]], pix.offset);
         host_u.tick();
      end
   endtask : pat
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         host_u.xfer(1'b0, 4'(i), 8'h00, q);
         chk("default", DEF[i], q);
      end
      // offsets start read-only, so the first row must be refused
      for (int i = 0; i < 11; i++) begin
         host_u.xfer(1'b1, ROWS[i][0][3:0], ROWS[i][1], q);
         host_u.xfer(1'b0, ROWS[i][0][3:0], 8'h00, q);
         chk("register", ROWS[i][2], q);
      end
      host_u.line();
      chk("line", 8'h00, {7'h00, act});
      pat(8'he4, 4, 6);
      host_u.line();
      chk("line", 8'h01, {7'h00, act});
      pat(8'h1b, 2, 4);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      chk("reset", 8'h10, blk);
      chk("primary", 8'h4e, pc);
      chk("secondary", 8'h00, sc);
      chk("trim_a", 8'haa, ta);
      chk("trim_b", 8'h5a, tb);
      report_and_stop();
   end
endmodule : testbench
